/* nor_flash_host.sv */
// host controller that drives a parallel nor flash through its pins
// assumes flash inputs synchronous to clock_i and the tristate resolved
// outside from flash_o.dq_oe_n
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
module nor_flash_host #(
    parameter logic [31:0] PROG_TIMEOUT_CYC = 32'(`CYC_UP(`T_PROG_NS)),
    parameter logic [31:0] ERASE_TIMEOUT_CYC = 32'(`CYC_UP(`T_ERASE_NS)),
    parameter logic [31:0] SUSPEND_WAIT_CYC = 32'(`CYC_UP(`T_SUSPEND_NS))
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire flash_seq_pkg::cmd_t cmd_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic protect_i,
    output flash_seq_pkg::rsp_t rsp_o,
    output logic rsp_valid_o,
    output logic busy_o,
    output logic suspended_o,
    output flash_seq_pkg::pins_t flash_o,
    input wire logic [`DATA_W-1:0] dq_i
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [2:0] seq_len(input flash_seq_pkg::op_t op);
        case (op)
            flash_seq_pkg::OP_PROG: seq_len = `PROG_LEN;
            flash_seq_pkg::OP_SECTOR_ERASE,
            flash_seq_pkg::OP_BLOCK_ERASE,
            flash_seq_pkg::OP_CHIP_ERASE: seq_len = `ERASE_LEN;
            default: seq_len = `SINGLE_LEN;
        endcase
    endfunction

    // one bus cycle of a command sequence
    function automatic flash_seq_pkg::bus_word_t seq_word(
        input flash_seq_pkg::op_t op, input logic [2:0] step,
        input logic [`ADDR_W-1:0] addr, input logic [`DATA_W-1:0] data);
        flash_seq_pkg::bus_word_t w;
        w = '{`UNLOCK_ADDR1, `CODE_UNLOCK1};
        case (op)
            flash_seq_pkg::OP_SUSPEND: w = '{addr, `CODE_SUSPEND};
            flash_seq_pkg::OP_RESUME: w = '{addr, `CODE_RESUME};
            default: begin
                case (step)
                    3'h1, 3'h4: w = '{`UNLOCK_ADDR2, `CODE_UNLOCK2};
                    3'h2: w = (op == flash_seq_pkg::OP_PROG) ?
                        '{`UNLOCK_ADDR1, `CODE_PROG} :
                        '{`UNLOCK_ADDR1, `CODE_ERASE_SETUP};
                    // caller keeps target words erased; not checked here
                    3'h3: w = (op == flash_seq_pkg::OP_PROG) ?
                        '{addr, data} : w;
                    3'h5: begin
                        case (op)
                            flash_seq_pkg::OP_SECTOR_ERASE:
                                w = '{addr, `CODE_SECTOR_ERASE};
                            flash_seq_pkg::OP_BLOCK_ERASE:
                                w = '{addr, `CODE_BLOCK_ERASE};
                            default:
                                w = '{`UNLOCK_ADDR1, `CODE_CHIP_ERASE};
                        endcase
                    end
                    default: w = w;
                endcase
            end
        endcase
        return w;
    endfunction

    // same 2 KWord sector, or same 32 KWord block when blk is set
    function automatic logic same_region(input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] b, input logic blk);
        if (blk) begin
            return a[`ADDR_W-1:`BLOCK_LSB] == b[`ADDR_W-1:`BLOCK_LSB];
        end
        return a[`ADDR_W-1:`SECTOR_LSB] == b[`ADDR_W-1:`SECTOR_LSB];
    endfunction

    function automatic logic last_cyc(input logic [7:0] cnt,
        input logic [7:0] lim);
        return cnt == lim - 8'h01;
    endfunction

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************************************
    // sequencer
    // ****************************************************************
    flash_seq_pkg::seq_t q, d;
    logic refuse;
    logic erase_poll;
    logic tog;
    logic [1:0] agree;
    logic [31:0] limit;
    flash_seq_pkg::bus_word_t w;

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        cmd_ready_o = 1'b0;
        refuse = 1'b0;
        tog = q.rd_data[`TOGGLE_BIT];
        agree = 2'h0;
        limit = (q.op == flash_seq_pkg::OP_PROG) ?
            PROG_TIMEOUT_CYC : ERASE_TIMEOUT_CYC;
        erase_poll = q.op == flash_seq_pkg::OP_SECTOR_ERASE ||
            q.op == flash_seq_pkg::OP_BLOCK_ERASE ||
            q.op == flash_seq_pkg::OP_RESUME;
        case (q.state)
            flash_seq_pkg::ST_IDLE: begin
                cmd_ready_o = 1'b1;
                d.wp_n = ~protect_i;
                case (cmd_i.op)
                    flash_seq_pkg::OP_PROG: refuse = q.susp &&
                        same_region(cmd_i.addr, q.susp_addr,
                        q.susp_block);
                    flash_seq_pkg::OP_SECTOR_ERASE,
                    flash_seq_pkg::OP_BLOCK_ERASE: refuse = q.susp ||
                        (protect_i && cmd_i.addr[`ADDR_W-1:`BLOCK_LSB] ==
                        `PROT_BLOCK);
                    flash_seq_pkg::OP_CHIP_ERASE:
                        refuse = q.susp || protect_i;
                    flash_seq_pkg::OP_SUSPEND: refuse = 1'b1;
                    flash_seq_pkg::OP_RESUME: refuse = !q.susp;
                    default: refuse = 1'b0;
                endcase
                if (cmd_valid_i) begin
                    d.op = cmd_i.op;
                    d.addr = cmd_i.addr;
                    d.data = cmd_i.data;
                    d.step = 3'h0;
                    d.cnt = 8'h00;
                    d.tmo = 32'h0;
                    d.agree = 2'h0;
                    d.have_prev = 1'b0;
                    d.rsp = '{data: '0, error: 1'b0};
                    if (refuse) begin
                        d.rsp.error = 1'b1;
                        d.rsp_valid = 1'b1;
                    end else if (cmd_i.op == flash_seq_pkg::OP_READ) begin
                        d.state = flash_seq_pkg::ST_RD_ACC;
                    end else begin
                        if (cmd_i.op == flash_seq_pkg::OP_RESUME) begin
                            d.susp = 1'b0;
                        end
                        d.state = flash_seq_pkg::ST_WR_SET;
                    end
                end
            end
            flash_seq_pkg::ST_WR_SET: begin
                d.cnt = q.cnt + 8'h01;
                if (last_cyc(q.cnt, 8'(`CYC_UP(`T_SETUP_NS)))) begin
                    d.cnt = 8'h00;
                    d.state = flash_seq_pkg::ST_WR_LOW;
                end
            end
            flash_seq_pkg::ST_WR_LOW: begin
                d.cnt = q.cnt + 8'h01;
                if (last_cyc(q.cnt, 8'(`CYC_UP(`T_WE_LOW_NS)))) begin
                    d.cnt = 8'h00;
                    d.state = flash_seq_pkg::ST_WR_HIGH;
                end
            end
            flash_seq_pkg::ST_WR_HIGH: begin
                d.cnt = q.cnt + 8'h01;
                if (last_cyc(q.cnt, 8'(`CYC_UP(`T_WE_HIGH_NS)))) begin
                    d.cnt = 8'h00;
                    d.step = q.step + 3'h1;
                    d.state = flash_seq_pkg::ST_WR_SET;
                    if (q.step == seq_len(q.op) - 3'h1) begin
                        d.tmo = 32'h0;
                        // status is valid once the last strobe has risen
                        d.state = (q.op == flash_seq_pkg::OP_SUSPEND) ?
                            flash_seq_pkg::ST_WAIT :
                            flash_seq_pkg::ST_RD_ACC;
                    end
                end
            end
            flash_seq_pkg::ST_RD_ACC: begin
                d.cnt = q.cnt + 8'h01;
                d.tmo = q.tmo + 32'h1;
                if (last_cyc(q.cnt, 8'(`CYC_UP(`T_ACCESS_NS)))) begin
                    d.cnt = 8'h00;
                    d.rd_data = dq_i;
                    d.state = flash_seq_pkg::ST_RD_REC;
                end
            end
            flash_seq_pkg::ST_RD_REC: begin
                d.cnt = q.cnt + 8'h01;
                d.tmo = q.tmo + 32'h1;
                if (last_cyc(q.cnt, 8'(`CYC_UP(`T_READ_REC_NS)))) begin
                    d.cnt = 8'h00;
                    d.state = flash_seq_pkg::ST_RD_ACC;
                    // busy while the toggle bit keeps alternating
                    if (q.have_prev && tog == q.prev_tog) begin
                        agree = q.agree + 2'h1;
                    end
                    d.agree = agree;
                    d.have_prev = 1'b1;
                    d.prev_tog = tog;
                    if (q.op == flash_seq_pkg::OP_READ) begin
                        d.rsp = '{data: q.rd_data, error: 1'b0};
                        d.rsp_valid = 1'b1;
                        d.state = flash_seq_pkg::ST_IDLE;
                    end else if (agree == `POLL_CONFIRM) begin
                        d.rsp.data = q.rd_data;
                        d.rsp.error = (q.op == flash_seq_pkg::OP_PROG) ?
                            q.rd_data[`POLL_BIT] != q.data[`POLL_BIT] :
                            !q.rd_data[`POLL_BIT];
                        d.tmo = 32'h0;
                        d.state = flash_seq_pkg::ST_WAIT;
                    end else if (q.tmo >= limit) begin
                        d.rsp.error = 1'b1;
                        d.rsp_valid = 1'b1;
                        d.state = flash_seq_pkg::ST_IDLE;
                    end else if (erase_poll && cmd_valid_i &&
                        cmd_i.op == flash_seq_pkg::OP_SUSPEND) begin
                        cmd_ready_o = 1'b1;
                        if (q.op != flash_seq_pkg::OP_RESUME) begin
                            d.susp_addr = q.addr;
                            d.susp_block =
                                q.op == flash_seq_pkg::OP_BLOCK_ERASE;
                        end
                        d.op = flash_seq_pkg::OP_SUSPEND;
                        d.addr = cmd_i.addr;
                        d.step = 3'h0;
                        d.state = flash_seq_pkg::ST_WR_SET;
                    end
                end
            end
            flash_seq_pkg::ST_WAIT: begin
                d.tmo = q.tmo + 32'h1;
                if (q.tmo == ((q.op == flash_seq_pkg::OP_SUSPEND) ?
                    SUSPEND_WAIT_CYC : 32'(`CYC_UP(`T_SETTLE_NS))) -
                    32'h1) begin
                    if (q.op == flash_seq_pkg::OP_SUSPEND) begin
                        d.susp = 1'b1;
                    end
                    d.rsp_valid = 1'b1;
                    d.state = flash_seq_pkg::ST_IDLE;
                end
            end
            default: d.state = flash_seq_pkg::ST_IDLE;
        endcase

        // pins follow the state being entered, so they come from flops
        w = seq_word(d.op, d.step, d.addr, d.data);
        d.pins = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, wp_n: d.wp_n,
            addr: d.addr, dq: q.pins.dq, dq_oe_n: 1'b1};
        case (d.state)
            flash_seq_pkg::ST_WR_SET, flash_seq_pkg::ST_WR_LOW,
            flash_seq_pkg::ST_WR_HIGH: begin
                // output enable stays high whenever the host drives data
                d.pins.ce_n = 1'b0;
                d.pins.we_n = d.state != flash_seq_pkg::ST_WR_LOW;
                d.pins.addr = w.addr;
                d.pins.dq = w.data;
                d.pins.dq_oe_n = 1'b0;
            end
            flash_seq_pkg::ST_RD_ACC: begin
                d.pins.ce_n = 1'b0;
                d.pins.oe_n = 1'b0;
            end
            default: d.pins.ce_n = 1'b1;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{state: flash_seq_pkg::ST_IDLE, op: flash_seq_pkg::OP_READ,
                wp_n: 1'b1, pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                wp_n: 1'b1, addr: '0, dq: '0, dq_oe_n: 1'b1},
                default: '0};
        end else begin
            q <= d;
        end
    end

    assign rsp_o = q.rsp;
    assign rsp_valid_o = q.rsp_valid;
    assign busy_o = q.state != flash_seq_pkg::ST_IDLE;
    assign suspended_o = q.susp;
    assign flash_o = q.pins;

endmodule
`default_nettype wire

/* flash_seq_map.svh */
// constants of the parallel nor flash command sequencer host
// assumes a 250 MHz clock and the flash pins wired straight to the host
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

`define ADDR_W 20
`define DATA_W 16
`define BLOCK_LSB 15
`define SECTOR_LSB 11
`define PROT_BLOCK 5'h00
`define UNLOCK_ADDR1 20'h05555
`define UNLOCK_ADDR2 20'h02aaa
`define CODE_UNLOCK1 16'h00aa
`define CODE_UNLOCK2 16'h0055
`define CODE_PROG 16'h00a0
`define CODE_ERASE_SETUP 16'h0080
`define CODE_SECTOR_ERASE 16'h0030
`define CODE_BLOCK_ERASE 16'h0050
`define CODE_CHIP_ERASE 16'h0010
`define CODE_SUSPEND 16'h00b0
`define CODE_RESUME 16'h0030
`define PROG_LEN 3'h4
`define ERASE_LEN 3'h6
`define SINGLE_LEN 3'h1
`define TOGGLE_BIT 6
`define POLL_BIT 7
`define POLL_CONFIRM 2'h3

`define CLK_NS 4
`define T_SETUP_NS 10
`define T_WE_LOW_NS 40
`define T_WE_HIGH_NS 30
`define T_ACCESS_NS 70
`define T_READ_REC_NS 20
`define T_PROG_NS 40000
`define T_SETTLE_NS 1000
`define T_SUSPEND_NS 20000
`define T_ERASE_NS 100000000
`define CYC_UP(t) (((t) + `CLK_NS - 1) / `CLK_NS)

`endif

/* flash_seq_pkg.sv */
// types of the parallel nor flash command sequencer host
// assumes flash_seq_map.svh is on the include path
`default_nettype none
`include "flash_seq_map.svh"
package flash_seq_pkg;

    typedef enum logic [2:0] {
        OP_READ, OP_PROG, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
        OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WR_SET, ST_WR_LOW, ST_WR_HIGH,
        ST_RD_ACC, ST_RD_REC, ST_WAIT
    } state_t;

    typedef struct packed {
        op_t op;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        logic [`DATA_W-1:0] data;
        logic error;
    } rsp_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } bus_word_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic wp_n;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] dq;
        logic dq_oe_n;
    } pins_t;

    typedef struct packed {
        state_t state;
        op_t op;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
        logic wp_n;
        logic [2:0] step;
        logic [7:0] cnt;
        logic [31:0] tmo;
        logic [1:0] agree;
        logic have_prev;
        logic prev_tog;
        logic [`DATA_W-1:0] rd_data;
        logic susp;
        logic [`ADDR_W-1:0] susp_addr;
        logic susp_block;
        pins_t pins;
        rsp_t rsp;
        logic rsp_valid;
    } seq_t;

endpackage
`default_nettype wire

/* nor_flash_host_monitor.sv */
// port checks for the nor flash host controller
// assumes it is bound into every nor_flash_host instance
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
module nor_flash_host_monitor #(
    parameter logic [31:0] PROG_TIMEOUT_CYC = 32'h2710,
    parameter logic [31:0] ERASE_TIMEOUT_CYC = 32'h17d7840,
    parameter logic [31:0] SUSPEND_WAIT_CYC = 32'h1388
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire flash_seq_pkg::cmd_t cmd_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire logic protect_i,
    input wire flash_seq_pkg::rsp_t rsp_o,
    input wire logic rsp_valid_o,
    input wire logic busy_o,
    input wire logic suspended_o,
    input wire flash_seq_pkg::pins_t flash_o,
    input wire logic [`DATA_W-1:0] dq_i
);
    // ********
    // checks
    // ********
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    assign take = cmd_valid_i && cmd_ready_o && !busy_o && !suspended_o;

    strobe_select_a: assert property (!flash_o.we_n |-> !flash_o.ce_n)
        else $error("write strobe low without chip select");
    strobe_width_a: assert property ($fell(flash_o.we_n) |->
        ##9 !flash_o.we_n ##1 flash_o.we_n)
        else $error("write strobe low time wrong");
    write_stable_a: assert property (!flash_o.we_n |->
        $stable(flash_o.addr) && $stable(flash_o.dq) && !flash_o.dq_oe_n)
        else $error("address or data moved during strobe");
    bus_turn_a: assert property (!flash_o.dq_oe_n |-> flash_o.oe_n)
        else $error("output enable low while host drives data");
    read_path_a: assert property (take &&
        cmd_i.op == flash_seq_pkg::OP_READ |->
        ##1 (!flash_o.ce_n && !flash_o.oe_n) ##23 rsp_valid_o)
        else $error("read cycle shape wrong");
    prog_words_a: assert property (take &&
        cmd_i.op == flash_seq_pkg::OP_PROG |->
        ##4 (!flash_o.we_n && flash_o.addr == `UNLOCK_ADDR1 &&
        flash_o.dq == `CODE_UNLOCK1) ##63 (!flash_o.we_n &&
        flash_o.addr == $past(cmd_i.addr, 67) &&
        flash_o.dq == $past(cmd_i.data, 67)))
        else $error("program sequence wrong");
    chip_final_a: assert property (take && !protect_i &&
        cmd_i.op == flash_seq_pkg::OP_CHIP_ERASE |-> ##109
        (!flash_o.we_n && flash_o.addr == `UNLOCK_ADDR1 &&
        flash_o.dq == `CODE_CHIP_ERASE))
        else $error("chip erase last cycle wrong");
    sector_final_a: assert property (take &&
        cmd_i.op == flash_seq_pkg::OP_SECTOR_ERASE &&
        (!protect_i || cmd_i.addr[19:15] != `PROT_BLOCK) |-> ##109
        (!flash_o.we_n && flash_o.dq == `CODE_SECTOR_ERASE &&
        flash_o.addr == $past(cmd_i.addr, 109)))
        else $error("sector erase last cycle wrong");
    protect_refuse_a: assert property (take && protect_i &&
        cmd_i.op == flash_seq_pkg::OP_CHIP_ERASE |=>
        rsp_valid_o && rsp_o.error && flash_o.ce_n)
        else $error("protected chip erase not refused");
    suspend_idle_a: assert property (take &&
        cmd_i.op == flash_seq_pkg::OP_SUSPEND |=> rsp_valid_o && rsp_o.error)
        else $error("idle suspend not refused");
    wp_steady_a: assert property (busy_o && $past(busy_o) |->
        $stable(flash_o.wp_n))
        else $error("protect pin moved during a sequence");
endmodule

bind nor_flash_host nor_flash_host_monitor #(
    .PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC),
    .ERASE_TIMEOUT_CYC(ERASE_TIMEOUT_CYC),
    .SUSPEND_WAIT_CYC(SUSPEND_WAIT_CYC)
) monitor (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .protect_i(protect_i), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o),
    .busy_o(busy_o), .suspended_o(suspended_o), .flash_o(flash_o),
    .dq_i(dq_i));
`default_nettype wire

/* nor_flash_model.sv */
// behavioural parallel nor flash seen from its pins
// assumes clk_i only paces internal program and erase time
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
module nor_flash_model #(
    parameter int PROG_CYC = 500,
    parameter int ERASE_CYC = 4000
) (
    input wire logic clk_i,
    input wire flash_seq_pkg::pins_t pins_i,
    output logic [`DATA_W-1:0] dq_o
);
    // ********
    // array and sequence state
    // ********
    logic [`DATA_W-1:0] mem [int];
    logic [`ADDR_W-1:0] lat_a, reg_a;
    logic [`DATA_W-1:0] pdata, v;
    logic pbusy = 0, ebusy = 0, susp = 0, blk = 0, chip = 0;
    logic tog = 0, tog2 = 0;
    int step = 0, pcnt, ecnt;
    wire logic sel = !pins_i.ce_n && !pins_i.oe_n;

    function automatic logic hit(input logic [`ADDR_W-1:0] a);
        hit = blk ? a[19:`BLOCK_LSB] == reg_a[19:`BLOCK_LSB]
                  : a[19:`SECTOR_LSB] == reg_a[19:`SECTOR_LSB];
    endfunction
    function automatic logic [`DATA_W-1:0] rd(input logic [`ADDR_W-1:0] a);
        rd = mem.exists(a) ? mem[a] : '1;
    endfunction

    task automatic take(input logic [`ADDR_W-1:0] a,
                        input logic [`DATA_W-1:0] d);
        if (pbusy || (ebusy && !susp)) begin
            if (!pbusy && !chip && d == `CODE_SUSPEND) susp = 1;
            return;
        end
        if (susp && step == 0 && d == `CODE_RESUME) begin
            susp = 0;
            return;
        end
        case (step)
            0: step = a == `UNLOCK_ADDR1 && d == `CODE_UNLOCK1 ? 1 : 0;
            1, 4: step = a == `UNLOCK_ADDR2 && d == `CODE_UNLOCK2 ?
                      step + 1 : 0;
            2: step = a != `UNLOCK_ADDR1 ? 0 : d == `CODE_PROG ? 7 :
                      d == `CODE_ERASE_SETUP ? 3 : 0;
            3: step = a == `UNLOCK_ADDR1 && d == `CODE_UNLOCK1 ? 4 : 0;
            5: begin
                step = 0;
                if (susp || !(d == `CODE_SECTOR_ERASE || d == `CODE_BLOCK_ERASE
                    || (d == `CODE_CHIP_ERASE && a == `UNLOCK_ADDR1))) return;
                chip = d == `CODE_CHIP_ERASE;
                blk = d == `CODE_BLOCK_ERASE;
                if (!pins_i.wp_n && (chip || a[19:15] == `PROT_BLOCK))
                    return;
                reg_a = a;
                ebusy = 1;
                ecnt = ERASE_CYC;
                foreach (mem[k]) if (chip || hit(20'(k))) mem[k] = '1;
            end
            7: begin
                step = 0;
                if (susp && hit(a)) return;
                mem[a] = rd(a) & d;
                pdata = d;
                pbusy = 1;
                pcnt = PROG_CYC;
            end
            default: step = 0;
        endcase
    endtask

    always @(negedge pins_i.we_n) if (!pins_i.ce_n) lat_a = pins_i.addr;
    always @(posedge pins_i.we_n)
        if (!pins_i.ce_n) take(lat_a, pins_i.dq);

    always @(posedge clk_i) begin
        if (pbusy && --pcnt == 0) pbusy = 0;
        if (ebusy && !susp && --ecnt == 0) ebusy = 0;
    end

    // reads answer at once: waking from low power costs nothing
    always @(posedge sel) begin
        if (pbusy) begin
            tog = !tog;
            v = ~pdata;
            v[6] = tog;
        end else if (ebusy && !susp) begin
            tog = !tog;
            tog2 = !tog2;
            v = {9'h000, tog, 3'h0, tog2, 2'h0};
        end else if (susp && hit(pins_i.addr)) begin
            tog2 = !tog2;
            v = {8'h00, 2'h3, 3'h0, tog2, 2'h0};
        end else v = rd(pins_i.addr);
        dq_o = v;
    end
    // no keeper on the data lines: released bus must not look valid
    always @(negedge sel) dq_o = ~dq_o;
endmodule
`default_nettype wire

/* nor_flash_host_tb.sv */
// self-checking bench for the nor flash host controller
// assumes the flash model and the bound port monitor
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
`define CHECK_EQ(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
    end \
end
module nor_flash_host_tb;
    // ********
    // harness
    // ********
    typedef flash_seq_pkg::op_t op_t;
    typedef flash_seq_pkg::rsp_t rsp_t;
    localparam op_t rd = flash_seq_pkg::OP_READ;
    localparam op_t pg = flash_seq_pkg::OP_PROG;
    localparam op_t se = flash_seq_pkg::OP_SECTOR_ERASE;
    localparam op_t be = flash_seq_pkg::OP_BLOCK_ERASE;
    localparam op_t ce = flash_seq_pkg::OP_CHIP_ERASE;
    localparam op_t su = flash_seq_pkg::OP_SUSPEND;
    localparam op_t re = flash_seq_pkg::OP_RESUME;
    logic clock_i = 0;
    logic rst_n_i = 0;
    flash_seq_pkg::cmd_t cmd_i = '0;
    logic cmd_valid_i = 0;
    logic protect_i = 0;
    logic cmd_ready_o, rsp_valid_o, busy_o, suspended_o;
    rsp_t rsp_o;
    flash_seq_pkg::pins_t flash_o;
    logic [`DATA_W-1:0] model_dq, dq_bus;
    int failures = 0, samples_checked = 0, cycles = 0;
    assign dq_bus = flash_o.dq_oe_n ? model_dq : flash_o.dq;
    always #2 clock_i = ~clock_i;

    nor_flash_host #(.PROG_TIMEOUT_CYC(32'h7d0),
        .ERASE_TIMEOUT_CYC(32'h1f40), .SUSPEND_WAIT_CYC(32'h14)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .protect_i(protect_i), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o),
        .busy_o(busy_o), .suspended_o(suspended_o), .flash_o(flash_o),
        .dq_i(dq_bus));
    nor_flash_model #(.PROG_CYC(500), .ERASE_CYC(4000)) flash (
        .clk_i(clock_i), .pins_i(flash_o), .dq_o(model_dq));

    task automatic send(input op_t op, input logic [19:0] a,
                        input logic [15:0] d);
        @(posedge clock_i);
        cmd_i <= '{op, a, d};
        cmd_valid_i <= 1'b1;
        do @(negedge clock_i); while (cmd_ready_o !== 1'b1);
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
    endtask
    task automatic run(input op_t op, input logic [19:0] a,
                       input logic [15:0] d, output rsp_t r);
        send(op, a, d);
        do @(negedge clock_i); while (rsp_valid_o !== 1'b1);
        r = rsp_o;
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_program();
        rsp_t r;
        run(pg, 20'h12345, 16'h5a3c, r);
        `CHECK_EQ(r.error, 1'b0)
        `CHECK_EQ(busy_o, 1'b0)
        run(rd, 20'h12345, 16'h0000, r);
        `CHECK_EQ(r.data, 16'h5a3c)
        $display("test program done");
    endtask
    task automatic t_refuse();
        rsp_t r;
        op_t ops [4] = '{su, re, ce, be};
        @(posedge clock_i);
        protect_i <= 1'b1;
        foreach (ops[i]) begin
            run(ops[i], 20'h00800, 16'h0000, r);
            `CHECK_EQ(r.error, 1'b1)
        end
        $display("test refuse done");
    endtask
    task automatic t_suspend();
        rsp_t r, s;
        send(se, 20'h12000, 16'h0000);
        run(su, 20'h00000, 16'h0000, r);
        `CHECK_EQ(r.error, 1'b0)
        `CHECK_EQ(suspended_o, 1'b1)
        run(rd, 20'h12345, 16'h0000, r);
        run(rd, 20'h12345, 16'h0000, s);
        `CHECK_EQ(s.data[7:6], 2'b11)
        `CHECK_EQ(s.data[2], !r.data[2])
        run(pg, 20'h12400, 16'h1111, r);
        `CHECK_EQ(r.error, 1'b1)
        run(pg, 20'h20010, 16'h0f0f, r);
        `CHECK_EQ(r.error, 1'b0)
        run(rd, 20'h20010, 16'h0000, r);
        `CHECK_EQ(r.data, 16'h0f0f)
        run(be, 20'h40000, 16'h0000, r);
        `CHECK_EQ(r.error, 1'b1)
        run(re, 20'h33333, 16'h0000, r);
        `CHECK_EQ(r.error, 1'b0)
        `CHECK_EQ(suspended_o, 1'b0)
        run(rd, 20'h12345, 16'h0000, r);
        `CHECK_EQ(r.data, 16'hffff)
        @(posedge clock_i);
        protect_i <= 1'b0;
        $display("test suspend done");
    endtask
    task automatic t_erase();
        rsp_t r;
        run(pg, 20'h00010, 16'h0f0f, r);
        run(pg, 20'h00800, 16'h1234, r);
        run(se, 20'h007ff, 16'h0000, r);
        `CHECK_EQ(r.error, 1'b0)
        run(rd, 20'h00010, 16'h0000, r);
        `CHECK_EQ(r.data, 16'hffff)
        run(rd, 20'h00800, 16'h0000, r);
        `CHECK_EQ(r.data, 16'h1234)
        run(be, 20'h00000, 16'h0000, r);
        run(rd, 20'h00800, 16'h0000, r);
        `CHECK_EQ(r.data, 16'hffff)
        run(ce, 20'h00000, 16'h0000, r);
        `CHECK_EQ(r.error, 1'b0)
        run(rd, 20'h20010, 16'h0000, r);
        `CHECK_EQ(r.data, 16'hffff)
        $display("test erase done");
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // a hung handshake ends the run here rather than never
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_program();
        t_refuse();
        t_suspend();
        t_erase();
        conclude();
    end
endmodule
`default_nettype wire
